/* File: design/rss_pkg.sv */
/*
 rss_pkg: constants and types for the receiver station stop/alarm control.
 assumes a 200 MHz system clock; shared by the control module and the bench.
*/
package rss_pkg;

   // clock and timing
   localparam int unsigned CLK_KHZ        = 200000;
   localparam int unsigned BLINK_MS       = 5000;
   localparam longint      BLINK_CYC      = longint'(BLINK_MS) * longint'(CLK_KHZ);
   localparam int unsigned DEBOUNCE_US    = 10000;
   localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_US * (CLK_KHZ / 1000);

   // register port
   localparam int unsigned ADDR_W         = 4;
   localparam int unsigned DATA_W         = 32;
   localparam logic [3:0]  OFS_BLINK      = 4'h0;
   localparam logic [3:0]  OFS_STATUS     = 4'h4;
   localparam logic [31:0] RST_BLINK      = 32'(BLINK_CYC);

   // debounced input indices
   localparam int unsigned BTN_STOP       = 0;
   localparam int unsigned BTN_LOW_TAPE   = 1;
   localparam int unsigned BTN_AUX_MOTOR  = 2;
   localparam int unsigned BTN_BYPASS     = 3;
   localparam int unsigned BTN_BLANK      = 4;
   localparam int unsigned BTN_ALL_MARK   = 5;
   localparam int unsigned BTN_TEST       = 6;
   localparam int unsigned BTN_MANUAL     = 7;
   localparam int unsigned NUM_BTN        = 8;

   // stop/hold sequencer
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_MOMENT,
      ST_HELD,
      ST_RESETTING
   } rss_stop_t;

   // status word field positions
   localparam int unsigned STS_FAULT      = 0;
   localparam int unsigned STS_LOW_TAPE   = 1;
   localparam int unsigned STS_BLINK      = 2;
   localparam int unsigned STS_HALT       = 3;
   localparam int unsigned STS_SECOND     = 4;
   localparam int unsigned STS_MOTOR      = 5;
   localparam int unsigned STS_DSR        = 6;
   localparam int unsigned STS_STATE      = 8;

   typedef struct packed {
      logic [21:0] rsvd;
      logic [1:0]  state;
      logic        rsvd7;
      logic        dsr;
      logic        motor;
      logic        second;
      logic        halt;
      logic        blink;
      logic        low_tape;
      logic        fault;
   } rss_status_t;

endpackage

/* File: design/rss_station_ctrl.sv */
/*
 rss_station_ctrl: station control for a paper-tape receiver: fault flag,
 low-tape latch and blinker, stop/hold sequencing, motor power and feed routing.
 assumes every panel, alarm and data set input is asynchronous to I_MCLK; register port is single-cycle.
*/
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
module rss_station_ctrl #(
   parameter int unsigned DEB_CYC   = rss_pkg::DEBOUNCE_CYC,
   parameter logic [31:0] BLINK_RST = rss_pkg::RST_BLINK
) (
   // clock and reset
   input  wire logic                       I_MCLK,
   input  wire logic                       I_ARST_N,
   // checking module
   input  wire logic                       I_FEED_ALARM,
   input  wire logic                       I_BACKUP_ALARM,
   input  wire logic                       I_PUNCH_TEST_ALARM,
   input  wire logic                       I_REV_CHAN_REQ,
   output logic                            O_BYPASS_CHECK_REQ,
   output logic                            O_ALL_MARK_CHECK,
   // data set
   input  wire logic                       I_DATA_SET_READY,
   input  wire logic                       I_CARRIER_DETECT,
   output logic                            O_PUNCH_BLIND,
   output logic                            O_REV_CHAN_ON,
   // operator panel and tape supply
   input  wire logic                       I_STOP_RESET_BTN,
   input  wire logic                       I_LOW_TAPE_SW,
   input  wire logic                       I_AUX_MOTOR_BTN,
   input  wire logic                       I_BYPASS_CHECK_BTN,
   input  wire logic                       I_BLANK_FEED_BTN,
   input  wire logic                       I_ALL_MARK_BTN,
   input  wire logic                       I_TEST_POS,
   input  wire logic                       I_MANUAL_MODE,
   // lamps
   output logic                            O_POWER_LAMP,
   output logic                            O_STOP_LAMP,
   output logic                            O_AUX_MOTOR_LAMP,
   output logic                            O_MANUAL_LAMP,
   output logic                            O_BYPASS_CHECK_LAMP,
   // punch and motors
   output logic                            O_MOTOR_POWER_EN,
   output logic                            O_BLANK_FEED,
   output logic                            O_ALL_MARK_FEED,
   // state view
   output logic                            O_FAULT_FLAG,
   output logic                            O_LOW_TAPE_LATCH,
   output logic                            O_HALT_FLAG,
   output logic                            O_SECOND_STAGE,
   // register port
   input  wire logic [rss_pkg::ADDR_W-1:0] I_REG_ADDR,
   input  wire logic [rss_pkg::DATA_W-1:0] I_REG_WDATA,
   input  wire logic                       I_REG_WR,
   input  wire logic                       I_REG_RD,
   output logic      [rss_pkg::DATA_W-1:0] O_REG_RDATA
);
   import rss_pkg::*;

   // elaboration checks; a zero count would never accept a button level
   if (DEB_CYC < 1) begin : g_deb_chk
      $error("DEB_CYC must be at least one");
   end
   if (BLINK_RST < 32'h0000_0001) begin : g_blink_chk
      $error("BLINK_RST must be at least one");
   end

   // raw button vector, packed by index
   logic [NUM_BTN-1:0] btn_raw;
   assign btn_raw[BTN_STOP]      = I_STOP_RESET_BTN;
   assign btn_raw[BTN_LOW_TAPE]  = I_LOW_TAPE_SW;
   assign btn_raw[BTN_AUX_MOTOR] = I_AUX_MOTOR_BTN;
   assign btn_raw[BTN_BYPASS]    = I_BYPASS_CHECK_BTN;
   assign btn_raw[BTN_BLANK]     = I_BLANK_FEED_BTN;
   assign btn_raw[BTN_ALL_MARK]  = I_ALL_MARK_BTN;
   assign btn_raw[BTN_TEST]      = I_TEST_POS;
   assign btn_raw[BTN_MANUAL]    = I_MANUAL_MODE;

   // two-flop synchronisers; first stage read only by second
   logic [NUM_BTN-1:0] btn_s1_q;
   logic [NUM_BTN-1:0] btn_s2_q;
   logic [5:0]         lvl_s1_q;
   logic [5:0]         lvl_s2_q;

   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         btn_s1_q <= '0;
         btn_s2_q <= '0;
         lvl_s1_q <= '0;
         lvl_s2_q <= '0;
      end else begin
         btn_s1_q <= btn_raw;
         btn_s2_q <= btn_s1_q;
         lvl_s1_q <= {I_BACKUP_ALARM, I_REV_CHAN_REQ, I_CARRIER_DETECT,
                      I_DATA_SET_READY, I_PUNCH_TEST_ALARM, I_FEED_ALARM};
         lvl_s2_q <= lvl_s1_q;
      end
   end

   // debounce: a level is accepted only after it stays put DEB_CYC cycles
   logic [31:0]        deb_cnt_q [NUM_BTN];
   logic [NUM_BTN-1:0] btn_q;
   logic [NUM_BTN-1:0] btn_prev_q;
   // chatter shorter than DEB_CYC never reaches btn_q

   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         for (int i = 0; i < NUM_BTN; i++) begin
            deb_cnt_q[i] <= '0;
         end
         btn_q      <= '0;
         btn_prev_q <= '0;
      end else begin
         btn_prev_q <= btn_q;
         for (int i = 0; i < NUM_BTN; i++) begin
            if (btn_s2_q[i] == btn_q[i]) begin
               deb_cnt_q[i] <= '0;
            end else if (deb_cnt_q[i] >= 32'(DEB_CYC - 1)) begin
               deb_cnt_q[i] <= '0;
               btn_q[i]     <= btn_s2_q[i];
            end else begin
               deb_cnt_q[i] <= deb_cnt_q[i] + 32'h0000_0001;
            end
         end
      end
   end

   logic stop_press;
   logic stop_release;
   logic test_pos;
   assign stop_press   = btn_q[BTN_STOP] & ~btn_prev_q[BTN_STOP];
   assign stop_release = ~btn_q[BTN_STOP] & btn_prev_q[BTN_STOP];
   assign test_pos     = btn_q[BTN_TEST];

   // synchronised levels; each alarm is synced alone, combined only after
   logic alarm_feed;
   logic alarm_backup;
   logic alarm_punch;
   logic dsr_line;
   logic carrier;
   logic rev_req;
   assign alarm_feed   = lvl_s2_q[0];
   assign alarm_punch  = lvl_s2_q[1];
   assign dsr_line     = lvl_s2_q[2];
   assign carrier      = lvl_s2_q[3];
   assign rev_req      = lvl_s2_q[4];
   assign alarm_backup = lvl_s2_q[5];

   // fault flag and call state
   logic fault_q;
   logic dsr_q;
   logic fault_d;
   logic dsr_d;
   logic fault_rise;
   logic call_end;
   assign fault_d    = alarm_feed | alarm_backup | alarm_punch;
   assign dsr_d      = dsr_line | test_pos;
   assign fault_rise = fault_d & ~fault_q;
   assign call_end   = dsr_q & ~dsr_d;

   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         fault_q <= 1'b0;
         dsr_q   <= 1'b0;
      end else begin
         fault_q <= fault_d;
         dsr_q   <= dsr_d;
      end
   end

   // low-tape latch; switch closure sets and wins over the alarm clear
   logic low_tape_q;

   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         low_tape_q <= 1'b0;
      end else if (btn_q[BTN_LOW_TAPE]) begin
         low_tape_q <= 1'b1;
      end else if (fault_rise) begin
         low_tape_q <= 1'b0;
      end
   end

   // blinker; the tick count is software-tunable for slow or fast lamps
   logic [31:0] blink_ticks_q;
   logic [31:0] blink_cnt_q;
   logic        blink_q;

   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         blink_cnt_q <= '0;
         blink_q     <= 1'b1;
      end else if (!low_tape_q) begin
         blink_cnt_q <= '0;
         blink_q     <= 1'b1;
      end else if (blink_cnt_q >= blink_ticks_q - 32'h0000_0001) begin
         blink_cnt_q <= '0;
         blink_q     <= ~blink_q;
      end else begin
         blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
      end
   end

   // stop/hold sequencer
   rss_stop_t state_q;

   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         state_q <= ST_IDLE;
      end else if (fault_d) begin
         // held state cannot be left while the fault stands
         state_q <= ST_HELD;
      end else begin
         case (state_q)
            ST_IDLE: begin
               // with a call up the press latches at once
               if (stop_press && dsr_d) begin
                  state_q <= ST_HELD;
               end else if (stop_press) begin
                  state_q <= ST_MOMENT;
               end
            end
            ST_MOMENT: begin
               if (stop_release) begin
                  state_q <= ST_IDLE;
               end else if (dsr_d) begin
                  state_q <= ST_HELD;
               end
            end
            ST_HELD: begin
               // call end wins over a press in the same cycle
               if (call_end) begin
                  state_q <= ST_IDLE;
               end else if (stop_press) begin
                  state_q <= ST_RESETTING;
               end
            end
            ST_RESETTING: begin
               // release re-arms the button for the next stop
               if (stop_release || call_end) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   logic halt;
   logic second;
   assign halt   = (state_q == ST_MOMENT) || (state_q == ST_HELD);
   assign second = (state_q == ST_HELD) || (state_q == ST_RESETTING);

   // registered outputs
   logic motor;
   assign motor = dsr_d | btn_q[BTN_AUX_MOTOR];

   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_FAULT_FLAG        <= 1'b0;
         O_LOW_TAPE_LATCH    <= 1'b0;
         O_POWER_LAMP        <= 1'b0;
         O_HALT_FLAG         <= 1'b0;
         O_SECOND_STAGE      <= 1'b0;
         O_STOP_LAMP         <= 1'b0;
         O_MOTOR_POWER_EN    <= 1'b0;
         O_AUX_MOTOR_LAMP    <= 1'b0;
         O_MANUAL_LAMP       <= 1'b0;
         O_BYPASS_CHECK_REQ  <= 1'b0;
         O_BYPASS_CHECK_LAMP <= 1'b0;
         O_PUNCH_BLIND       <= 1'b1;
         O_REV_CHAN_ON       <= 1'b0;
         O_BLANK_FEED        <= 1'b0;
         O_ALL_MARK_FEED     <= 1'b0;
         O_ALL_MARK_CHECK    <= 1'b0;
      end else begin
         O_FAULT_FLAG        <= fault_q;
         O_LOW_TAPE_LATCH    <= low_tape_q;
         O_POWER_LAMP        <= ~low_tape_q | blink_q;
         O_HALT_FLAG         <= halt;
         O_SECOND_STAGE      <= second;
         O_STOP_LAMP         <= halt | second;
         O_MOTOR_POWER_EN    <= motor;
         O_AUX_MOTOR_LAMP    <= btn_q[BTN_AUX_MOTOR];
         O_MANUAL_LAMP       <= btn_q[BTN_MANUAL] & ~btn_q[BTN_AUX_MOTOR];
         O_BYPASS_CHECK_REQ  <= btn_q[BTN_BYPASS];
         O_BYPASS_CHECK_LAMP <= btn_q[BTN_BYPASS];
         // carrier loss blinds the punch only outside test position
         O_PUNCH_BLIND       <= ~dsr_d | (~carrier & ~test_pos);
         O_REV_CHAN_ON       <= rev_req & ~halt & ~second & dsr_d
                                & (carrier | test_pos);
         O_BLANK_FEED        <= btn_q[BTN_BLANK] & motor;
         O_ALL_MARK_FEED     <= btn_q[BTN_ALL_MARK];
         O_ALL_MARK_CHECK    <= btn_q[BTN_ALL_MARK];
      end
   end

   // register port: writes take effect at once, reads answer next cycle
   rss_status_t status;

   always_comb begin
      status          = '0;
      status.fault    = fault_q;
      status.low_tape = low_tape_q;
      status.blink    = blink_q;
      status.halt     = halt;
      status.second   = second;
      status.motor    = motor;
      status.dsr      = dsr_q;
      status.state    = state_q;
   end

   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         blink_ticks_q <= BLINK_RST;
      end else if (I_REG_WR && I_REG_ADDR == OFS_BLINK) begin
         // zero would stall the blinker; treat it as one
         if (I_REG_WDATA == 32'h0000_0000) begin
            blink_ticks_q <= 32'h0000_0001;
         end else begin
            blink_ticks_q <= I_REG_WDATA;
         end
      end
   end

   // read data stand one cycle only, zero otherwise
   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_REG_RDATA <= '0;
      end else if (!I_REG_RD) begin
         O_REG_RDATA <= '0;
      end else if (I_REG_ADDR == OFS_BLINK) begin
         O_REG_RDATA <= blink_ticks_q;
      end else if (I_REG_ADDR == OFS_STATUS) begin
         O_REG_RDATA <= status;
      end else begin
         O_REG_RDATA <= '0;
      end
   end

endmodule

/* File: tb/rss_station_ctrl_props.sv */
/*
 rss_station_ctrl_props: port-level checks for the station control block.
 assumes a bind to rss_station_ctrl, one clock, async active-low reset.
*/
`timescale 1ns/1ps
module rss_station_ctrl_props (
   // clock, reset, inputs
   input wire logic I_MCLK,
   input wire logic I_ARST_N,
   input wire logic I_FEED_ALARM,
   input wire logic I_BACKUP_ALARM,
   input wire logic I_PUNCH_TEST_ALARM,
   input wire logic I_DATA_SET_READY,
   // watched outputs
   input wire logic O_FAULT_FLAG,
   input wire logic O_HALT_FLAG,
   input wire logic O_SECOND_STAGE,
   input wire logic O_STOP_LAMP,
   input wire logic O_REV_CHAN_ON,
   input wire logic O_MOTOR_POWER_EN,
   input wire logic O_BLANK_FEED,
   input wire logic O_AUX_MOTOR_LAMP,
   input wire logic O_MANUAL_LAMP,
   input wire logic O_BYPASS_CHECK_REQ,
   input wire logic O_BYPASS_CHECK_LAMP,
   input wire logic O_ALL_MARK_CHECK,
   input wire logic O_ALL_MARK_FEED,
   input wire logic O_LOW_TAPE_LATCH,
   input wire logic O_POWER_LAMP
);
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_ARST_N);
   logic any_alarm;
   assign any_alarm = I_FEED_ALARM | I_BACKUP_ALARM | I_PUNCH_TEST_ALARM;
   // five samples cover the two sync flops, fault_q and the output register
   a_fault_follows_alarm: assert property (any_alarm [*5] |-> O_FAULT_FLAG)
      else $error("fault flag missing under alarm");
   a_fault_drops_clear: assert property (!any_alarm [*5] |-> !O_FAULT_FLAG)
      else $error("fault flag without alarm");
   a_fault_sets_both: assert property ($rose(O_FAULT_FLAG) |->
      ##[0:2] (O_HALT_FLAG && O_SECOND_STAGE))
      else $error("fault did not set halt and second stage");
   a_no_reset_fault: assert property (O_FAULT_FLAG [*3] |-> O_HALT_FLAG && O_SECOND_STAGE)
      else $error("latches released while fault active");
   a_stop_lamp_or: assert property (O_STOP_LAMP == (O_HALT_FLAG | O_SECOND_STAGE))
      else $error("stop lamp mismatch");
   a_revchan_blocked: assert property (O_HALT_FLAG || O_SECOND_STAGE |-> !O_REV_CHAN_ON)
      else $error("reverse channel on while halted");
   a_motor_on_call: assert property (I_DATA_SET_READY [*5] |-> O_MOTOR_POWER_EN)
      else $error("motor power off during call");
   a_blank_needs_motor: assert property (!O_MOTOR_POWER_EN [*2] |-> !O_BLANK_FEED)
      else $error("blank feed without motor power");
   a_aux_kills_manual: assert property (O_AUX_MOTOR_LAMP |-> !O_MANUAL_LAMP)
      else $error("manual lamp on with aux motor");
   a_bypass_pair: assert property (O_BYPASS_CHECK_REQ == O_BYPASS_CHECK_LAMP)
      else $error("bypass request and lamp differ");
   a_allmark_pair: assert property (O_ALL_MARK_CHECK == O_ALL_MARK_FEED)
      else $error("all-mark outputs differ");
   // lamp leaves its reset level one edge after release, hence three samples
   a_lamp_steady_ok: assert property (!O_LOW_TAPE_LATCH [*3] |-> O_POWER_LAMP)
      else $error("power lamp off without low tape");
   c_call_halt: cover property (O_HALT_FLAG && I_DATA_SET_READY);
   c_rearm: cover property ($fell(O_SECOND_STAGE));
   c_blink: cover property ($rose(O_POWER_LAMP) && O_LOW_TAPE_LATCH);
endmodule

/* File: tb/rss_panel_model.sv */
/*
 rss_panel_model: operator buttons and tape supply switch with contact chatter.
 assumes the bench sets clean levels on i_cmd at the rising edge.
*/
`timescale 1ns/1ps
module rss_panel_model (
   // clean levels in
   input  wire logic       i_clk,
   input  wire logic [7:0] i_cmd,
   // contacts out
   output logic      [7:0] o_btn
);
   logic [7:0] cmd_q = 8'h00;
   logic [7:0] chg_q = 8'h00;
   logic [2:0] cnt_q = 3'h0;
   // every edge chatters two times, so one press must still be one event
   always @(posedge i_clk) begin
      if (i_cmd != cmd_q) begin
         chg_q <= i_cmd ^ cmd_q;
         cnt_q <= 3'h4;
      end else if (cnt_q != 3'h0) begin
         cnt_q <= cnt_q - 3'h1;
      end
      cmd_q <= i_cmd;
   end
   assign o_btn = cnt_q[0] ? (cmd_q ^ chg_q) : cmd_q;
endmodule

/* File: tb/rss_station_ctrl_bench.sv */
/*
 rss_station_ctrl_bench: self-checking bench for the station control block.
 assumes short debounce and blink counts; panel contacts come from the model.
*/
`timescale 1ns/1ps
module rss_station_ctrl_bench;
   import rss_pkg::*;
   logic mclk = 1'b0, arst_n = 1'b0, fa = 1'b0, ba = 1'b0, pa = 1'b0;
   logic rev_req = 1'b0, dsr = 1'b0, cd = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0] cmd = 8'h00;
   logic [7:0] btn_w;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic by_req, am_chk, blind, rev_on, pwr, stop, aux_l, man_l, by_l, mot, blank;
   logic am_feed, fault, lt, halt, sec;
   int fail_count = 0, tests_run = 0;
   always #2.5 mclk = ~mclk;
   rss_panel_model u_rss_panel_model (.i_clk(mclk), .i_cmd(cmd), .o_btn(btn_w));
   rss_station_ctrl #(.DEB_CYC(2), .BLINK_RST(32'h0000000A)) u_rss_station_ctrl (
      .I_MCLK(mclk), .I_ARST_N(arst_n), .I_FEED_ALARM(fa), .I_BACKUP_ALARM(ba),
      .I_PUNCH_TEST_ALARM(pa), .I_REV_CHAN_REQ(rev_req), .O_BYPASS_CHECK_REQ(by_req),
      .O_ALL_MARK_CHECK(am_chk), .I_DATA_SET_READY(dsr), .I_CARRIER_DETECT(cd),
      .O_PUNCH_BLIND(blind), .O_REV_CHAN_ON(rev_on), .I_STOP_RESET_BTN(btn_w[BTN_STOP]),
      .I_LOW_TAPE_SW(btn_w[BTN_LOW_TAPE]), .I_AUX_MOTOR_BTN(btn_w[BTN_AUX_MOTOR]),
      .I_BYPASS_CHECK_BTN(btn_w[BTN_BYPASS]), .I_BLANK_FEED_BTN(btn_w[BTN_BLANK]),
      .I_ALL_MARK_BTN(btn_w[BTN_ALL_MARK]), .I_TEST_POS(btn_w[BTN_TEST]),
      .I_MANUAL_MODE(btn_w[BTN_MANUAL]), .O_POWER_LAMP(pwr), .O_STOP_LAMP(stop),
      .O_AUX_MOTOR_LAMP(aux_l), .O_MANUAL_LAMP(man_l), .O_BYPASS_CHECK_LAMP(by_l),
      .O_MOTOR_POWER_EN(mot), .O_BLANK_FEED(blank), .O_ALL_MARK_FEED(am_feed),
      .O_FAULT_FLAG(fault), .O_LOW_TAPE_LATCH(lt), .O_HALT_FLAG(halt),
      .O_SECOND_STAGE(sec), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WR(wr),
      .I_REG_RD(rd), .O_REG_RDATA(rdata));
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // contact chatter plus sync and debounce settle well inside 14 cycles
   task automatic press(input int idx, input logic v);
      @(posedge mclk) cmd[idx] <= v;
      cyc(14);
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk) begin
         wr <= 1'b1; addr <= a; wdata <= d;
      end
      @(posedge mclk) wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp, input string name);
      @(posedge mclk) begin
         rd <= 1'b1; addr <= a;
      end
      @(posedge mclk) rd <= 1'b0;
      #1 chk(name, rdata, exp);
   endtask
   task automatic stop_cycle();
      press(BTN_STOP, 1'b1);
      press(BTN_STOP, 1'b0);
   endtask
   task automatic t_regs();
      reg_rd(4'h0, 32'h0000000A, "blink_ticks");
      reg_rd(4'h4, 32'h00000004, "status");
      reg_wr(4'h4, 32'hFFFFFFFF);
      reg_wr(4'h8, 32'h12345678);
      reg_rd(4'h4, 32'h00000004, "status_ro");
      reg_rd(4'h8, 32'h00000000, "unmapped");
      reg_wr(4'h0, 32'h00000000);
      reg_rd(4'h0, 32'h00000001, "blink_zero");
      reg_wr(4'h0, 32'h00000006);
      reg_rd(4'h0, 32'h00000006, "blink_six");
   endtask
   task automatic t_no_call();
      press(BTN_STOP, 1'b1);
      chk("halt_held", halt, 1'b1);
      press(BTN_STOP, 1'b0);
      chk("halt_released", halt, 1'b0);
   endtask
   task automatic t_call();
      @(posedge mclk) begin
         dsr <= 1'b1; rev_req <= 1'b1; cd <= 1'b1;
      end
      cyc(8);
      chk("rev_free", rev_on, 1'b1);
      chk("motor_call", mot, 1'b1);
      press(BTN_STOP, 1'b1);
      chk("halt_set", halt, 1'b1);
      chk("second_set", sec, 1'b1);
      chk("rev_blocked", rev_on, 1'b0);
      press(BTN_STOP, 1'b0);
      chk("halt_kept", halt, 1'b1);
      chk("lamp_kept", stop, 1'b1);
      press(BTN_STOP, 1'b1);
      chk("halt_cleared", halt, 1'b0);
      chk("second_kept", sec, 1'b1);
      chk("lamp_second", stop, 1'b1);
      press(BTN_STOP, 1'b0);
      chk("second_cleared", sec, 1'b0);
      chk("rev_back", rev_on, 1'b1);
      stop_cycle();
      @(posedge mclk) dsr <= 1'b0;
      cyc(8);
      chk("drop_halt", halt, 1'b0);
      chk("drop_second", sec, 1'b0);
      rev_req <= 1'b0;
      cd <= 1'b0;
   endtask
   task automatic t_alarms();
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk) {fa, ba, pa} <= 3'(1 << i);
         cyc(8);
         chk("fault_on", fault, 1'b1);
         chk("fault_second", sec, 1'b1);
         stop_cycle();
         chk("reset_refused", halt, 1'b1);
         @(posedge mclk) {fa, ba, pa} <= 3'b000;
         cyc(8);
         chk("fault_off", fault, 1'b0);
         chk("halt_persists", halt, 1'b1);
         stop_cycle();
         chk("halt_reset", halt | sec, 1'b0);
      end
   endtask
   task automatic t_low_tape();
      int n;
      logic prev;
      n = 0;
      press(BTN_LOW_TAPE, 1'b1);
      chk("lt_set", lt, 1'b1);
      press(BTN_LOW_TAPE, 1'b0);
      chk("lt_held", lt, 1'b1);
      prev = pwr;
      for (int k = 0; k < 60; k++) begin
         @(posedge mclk);
         #1;
         if (pwr !== prev) n++;
         prev = pwr;
      end
      chk("lamp_toggles", (n >= 8) && (n <= 11), 1'b1);
      @(posedge mclk) fa <= 1'b1;
      cyc(8);
      chk("lt_cleared", lt, 1'b0);
      @(posedge mclk) fa <= 1'b0;
      cyc(8);
      stop_cycle();
      chk("lamp_steady", pwr, 1'b1);
   endtask
   task automatic t_motor();
      press(BTN_BLANK, 1'b1);
      chk("blank_blocked", blank, 1'b0);
      chk("motor_idle", mot, 1'b0);
      press(BTN_MANUAL, 1'b1);
      chk("manual_lamp", man_l, 1'b1);
      press(BTN_AUX_MOTOR, 1'b1);
      chk("motor_aux", mot, 1'b1);
      chk("aux_lamp", aux_l, 1'b1);
      chk("manual_off", man_l, 1'b0);
      chk("blank_passed", blank, 1'b1);
      press(BTN_AUX_MOTOR, 1'b0);
      chk("blank_dropped", blank, 1'b0);
      press(BTN_BLANK, 1'b0);
      press(BTN_TEST, 1'b1);
      chk("motor_test", mot, 1'b1);
      chk("blind_test", blind, 1'b0);
      press(BTN_TEST, 1'b0);
      chk("blind_idle", blind, 1'b1);
      press(BTN_BYPASS, 1'b1);
      chk("bypass_req", {by_req, by_l}, 2'b11);
      press(BTN_BYPASS, 1'b0);
      press(BTN_ALL_MARK, 1'b1);
      chk("all_mark", {am_feed, am_chk}, 2'b11);
      press(BTN_ALL_MARK, 1'b0);
      press(BTN_MANUAL, 1'b0);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // a hang anywhere ends the run as a mismatch
   initial begin
      cyc(20000);
      fail_count++;
      report_and_stop();
   end
   initial begin
      cyc(4);
      @(posedge mclk) arst_n <= 1'b1;
      cyc(2);
      t_regs();
      $display("registers done");
      t_no_call();
      $display("idle stop done");
      t_call();
      $display("call stop done");
      t_alarms();
      $display("alarms done");
      t_low_tape();
      $display("low tape done");
      t_motor();
      $display("motor and feed done");
      report_and_stop();
   end
endmodule
bind rss_station_ctrl rss_station_ctrl_props u_rss_station_ctrl_props (
   .I_MCLK(I_MCLK), .I_ARST_N(I_ARST_N), .I_FEED_ALARM(I_FEED_ALARM),
   .I_BACKUP_ALARM(I_BACKUP_ALARM), .I_PUNCH_TEST_ALARM(I_PUNCH_TEST_ALARM),
   .I_DATA_SET_READY(I_DATA_SET_READY), .O_FAULT_FLAG(O_FAULT_FLAG),
   .O_HALT_FLAG(O_HALT_FLAG), .O_SECOND_STAGE(O_SECOND_STAGE), .O_STOP_LAMP(O_STOP_LAMP),
   .O_REV_CHAN_ON(O_REV_CHAN_ON), .O_MOTOR_POWER_EN(O_MOTOR_POWER_EN),
   .O_BLANK_FEED(O_BLANK_FEED), .O_AUX_MOTOR_LAMP(O_AUX_MOTOR_LAMP),
   .O_MANUAL_LAMP(O_MANUAL_LAMP), .O_BYPASS_CHECK_REQ(O_BYPASS_CHECK_REQ),
   .O_BYPASS_CHECK_LAMP(O_BYPASS_CHECK_LAMP), .O_ALL_MARK_CHECK(O_ALL_MARK_CHECK),
   .O_ALL_MARK_FEED(O_ALL_MARK_FEED), .O_LOW_TAPE_LATCH(O_LOW_TAPE_LATCH),
   .O_POWER_LAMP(O_POWER_LAMP));
